// ==== logic/hrs_pkg.sv ====
package hrs_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // One CPU clock half-period is taken as one reference clock cycle
  localparam int HALF_PERIOD_NS = CLK_PERIOD_NS;
  localparam int SYNC_LOW_EXTRA_NS = 10;
  localparam int ASYNC_LOW_NS = 1500;
  localparam int START_DELAY_HP = 4;
  localparam int START_DELAY_MAX_HP = 16;
  localparam int SEQ_LEN_HP = 1024;
  localparam int END_DELAY_HP = 4;
  localparam int END_DELAY_MAX_HP = 6;
  localparam int ALE_DELAY_HP = 8;
  localparam int CFG_HOLD_HP = 6;
  localparam int SYNC_STAGES = 2;
  // Cycles: start delay does not include the synchroniser stages
  localparam int START_WAIT_CYC = (START_DELAY_HP * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_CYC = (SEQ_LEN_HP * HALF_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int END_CYC = (END_DELAY_HP * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALE_CYC = (ALE_DELAY_HP * HALF_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int CNT_W = 11;

  // ---------------------------------------------------------------------------
  // Configuration port fields
  // ---------------------------------------------------------------------------
  localparam int CFG_EMU_BIT = 0;
  localparam int CFG_SELA_BIT = 1;
  localparam int CFG_CLK_LSB = 13;
  localparam int CFG_W = 16;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum logic [2:0] {
    HRS_IDLE,
    HRS_WAIT_START,
    HRS_SEQ,
    HRS_WAIT_END,
    HRS_WAIT_ALE,
    HRS_RUN
  } hrs_state_type;

  typedef struct packed {
    logic       emulation_select;
    logic       select_a;
    logic [2:0] clock_config;
  } hrs_cfg_type;

  typedef struct packed {
    hrs_state_type     state;
    logic [CNT_W-1:0]  cnt;
    logic              pull_low;
    logic              bus_drive;
    logic              ale;
    logic              internal_reset;
    logic              reset_indicator_n;
    logic              fetch_start;
    hrs_cfg_type       cfg;
  } hrs_ctrl_type;

endpackage

// ==== logic/hrs_sync.sv ====
module hrs_sync
  import hrs_pkg::*;
#(
  parameter int STAGES    = 2,
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic din,
  output logic      dout
);

  logic [STAGES-1:0] sync_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= {STAGES{RST_VAL}};
    end else if (clk_en) begin
      sync_reg <= {sync_reg[STAGES-2:0], din};
    end
  end

  assign dout = sync_reg[STAGES-1];

endmodule

// ==== logic/hrs_sequencer.sv ====
// Operation
// - Sequence starts 4..16 half-periods after request low, lasts 1024, pin pulled low.
// - Internal reset ends 4..6 half-periods after the pin returns high.
// - Bus signals released when reset request goes low.
// - Bus signals driven again once internal reset ends.
// - Address-latch strobe rises exactly 8 half-periods after internal reset ends.
// - Config bits 0, 1, 13..15 loaded continuously while internal reset is active.
// - Execution starts at address zero after reset.
// - Reset indicator stays asserted until end-of-init instruction executes.
// - Warm reset cancels pending holds and completes the running access first.
module hrs_sequencer
  import hrs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              reset_request_n_in,
  output logic                   reset_request_n_out,
  output logic                   reset_request_n_oe,
  input  wire logic [CFG_W-1:0]  config_port,
  input  wire logic              end_of_init_instruction,
  input  wire logic              access_busy,
  output logic                   hold_cancel,
  output logic                   bus_drive,
  output logic                   ale,
  output logic                   internal_reset,
  output logic                   reset_indicator_n,
  output logic                   fetch_start,
  output logic [15:0]            fetch_addr,
  output logic                   emulation_select,
  output logic                   select_a,
  output logic [2:0]             clock_config
);

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  logic req_n_sync;
  logic [CFG_W-1:0] cfg_meta_reg;
  logic [CFG_W-1:0] cfg_sync_reg;

  hrs_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b1)) u_req_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .din     (reset_request_n_in),
    .dout    (req_n_sync)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_meta_reg <= '1;
      cfg_sync_reg <= '1;
    end else if (clk_en) begin
      cfg_meta_reg <= config_port;
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  hrs_ctrl_type ctrl_reg;
  hrs_ctrl_type ctrl_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.fetch_start = 1'b0;
    if (ctrl_reg.cnt != '0) begin
      ctrl_next.cnt = ctrl_reg.cnt - 1'b1;
    end
    case (ctrl_reg.state)
      HRS_IDLE, HRS_RUN: begin
        if (!req_n_sync) begin
          ctrl_next.bus_drive = 1'b0;
          ctrl_next.ale = 1'b0;
          ctrl_next.state = HRS_WAIT_START;
          ctrl_next.cnt = cyc(START_WAIT_CYC);
        end else if (ctrl_reg.state == HRS_RUN && end_of_init_instruction) begin
          ctrl_next.reset_indicator_n = 1'b1;
        end
      end
      HRS_WAIT_START: begin
        // Let a running internal access finish before resetting
        if (ctrl_reg.cnt == '0 && !access_busy) begin
          ctrl_next.state = HRS_SEQ;
          ctrl_next.cnt = cyc(SEQ_CYC);
          ctrl_next.pull_low = 1'b1;
          ctrl_next.internal_reset = 1'b1;
          ctrl_next.reset_indicator_n = 1'b0;
        end
      end
      HRS_SEQ: begin
        if (ctrl_reg.cnt == '0) begin
          ctrl_next.pull_low = 1'b0;
          ctrl_next.state = HRS_WAIT_END;
        end
      end
      HRS_WAIT_END: begin
        // Pin still held low externally keeps the condition
        if (!req_n_sync) begin
          ctrl_next.cnt = cyc(END_CYC);
        end else if (ctrl_reg.cnt == '0) begin
          ctrl_next.internal_reset = 1'b0;
          ctrl_next.bus_drive = 1'b1;
          ctrl_next.state = HRS_WAIT_ALE;
          ctrl_next.cnt = cyc(ALE_CYC);
        end
      end
      HRS_WAIT_ALE: begin
        if (ctrl_reg.cnt == '0) begin
          ctrl_next.ale = 1'b1;
          ctrl_next.fetch_start = 1'b1;
          ctrl_next.state = HRS_RUN;
        end
      end
      default: ctrl_next.state = HRS_IDLE;
    endcase
    if (ctrl_next.internal_reset) begin
      ctrl_next.cfg.emulation_select = cfg_sync_reg[CFG_EMU_BIT];
      ctrl_next.cfg.select_a = cfg_sync_reg[CFG_SELA_BIT];
      ctrl_next.cfg.clock_config = cfg_sync_reg[CFG_CLK_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= '{state: HRS_IDLE, cnt: '0, pull_low: 1'b0, bus_drive: 1'b0, ale: 1'b0,
                    internal_reset: 1'b1, reset_indicator_n: 1'b0, fetch_start: 1'b0,
                    cfg: '{emulation_select: 1'b1, select_a: 1'b1, clock_config: 3'h7}};
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reset_request_n_out = 1'b0;
  assign reset_request_n_oe  = ctrl_reg.pull_low;
  assign hold_cancel         = (ctrl_reg.state == HRS_WAIT_START);
  assign bus_drive           = ctrl_reg.bus_drive;
  assign ale                 = ctrl_reg.ale;
  assign internal_reset      = ctrl_reg.internal_reset;
  assign reset_indicator_n   = ctrl_reg.reset_indicator_n;
  assign fetch_start         = ctrl_reg.fetch_start;
  assign fetch_addr          = RESET_VECTOR;
  assign emulation_select    = ctrl_reg.cfg.emulation_select;
  assign select_a            = ctrl_reg.cfg.select_a;
  assign clock_config        = ctrl_reg.cfg.clock_config;

  // ---------------------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------------------
  // Counts enabled cycles with the pin pulled low, for the sequence length check
  logic [CNT_W-1:0] oe_len_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oe_len_reg <= '0;
    end else if (clk_en) begin
      if (reset_request_n_oe) begin
        oe_len_reg <= oe_len_reg + 1'b1;
      end else begin
        oe_len_reg <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_SEQ_LEN: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && $rose(reset_request_n_oe) ##1 clk_en[*7] |-> reset_request_n_oe)
    else $error("Pull-low ended too early");
  AST_PULL_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrl_reg.state == HRS_SEQ && ctrl_reg.cnt == '0 && clk_en) |=> !reset_request_n_oe)
    else $error("Pull-low not released after sequence");
  AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !req_n_sync && ctrl_reg.state == HRS_RUN) |=> !bus_drive)
    else $error("Bus not released on reset request");
  AST_DRIVE: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(internal_reset) |-> bus_drive)
    else $error("Bus not driven after internal reset end");
  AST_ALE: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($fell(internal_reset) && clk_en) ##1 clk_en[*7] |=> ale)
    else $error("Latch strobe not at 8 half-periods");
  AST_ALE_EARLY: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(internal_reset) |-> !ale)
    else $error("Latch strobe too early");
  AST_CFG: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && ctrl_reg.state == HRS_SEQ) |=> emulation_select == $past(cfg_sync_reg[CFG_EMU_BIT]))
    else $error("Config bit not loaded during reset");
  AST_INDICATOR: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(reset_indicator_n) |-> $past(end_of_init_instruction))
    else $error("Reset indicator released without end of init");
  AST_END: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(internal_reset) |-> $past(req_n_sync, 4))
    else $error("Internal reset ended too soon after pin high");
  AST_SEQ_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(reset_request_n_oe) |-> oe_len_reg == CNT_W'(SEQ_CYC))
    else $error("Pull-low length differs from the sequence length");
  AST_END_MAX: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && ctrl_reg.state == HRS_WAIT_END && $rose(req_n_sync)) ##1 (clk_en && req_n_sync)[*4]
    |-> !internal_reset)
    else $error("Internal reset ended too late after pin high");
  AST_WAIT_ACCESS: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && hold_cancel && access_busy) |=> !reset_request_n_oe)
    else $error("Sequence started while an access was running");
  AST_INDICATOR_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(reset_request_n_oe) |-> !reset_indicator_n)
    else $error("Reset indicator not asserted at sequence start");

  COV_SEQ: cover property (@(posedge ref_clk) $rose(reset_request_n_oe));
  COV_END: cover property (@(posedge ref_clk) $fell(internal_reset));
  COV_ALE: cover property (@(posedge ref_clk) $rose(ale));
  COV_END_OF_INIT_INSTRUCTION: cover property (@(posedge ref_clk) $rose(reset_indicator_n));
  COV_WAIT_BUSY: cover property (@(posedge ref_clk) hold_cancel && access_busy);

endmodule

// ==== tb/hrs_reset_source.sv ====
module hrs_reset_source
  import hrs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             pin_oe,
  input  wire logic             pin_out,
  output logic                  pin_level,
  output logic [CFG_W-1:0]      cfg_level
);
  timeunit 1ns;
  timeprecision 1ps;

  int               low_cnt;
  logic [CFG_W-1:0] cfg_reg;

  initial begin
    low_cnt = 0;
    cfg_reg = '1;
  end

  // Open-drain pin with pullup: low while either party pulls it
  assign pin_level = ~((low_cnt != 0) | (pin_oe & ~pin_out));
  assign cfg_level = cfg_reg;

  // Source holds the pin low for exactly the commanded number of cycles
  always @(posedge ref_clk) begin
    if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end

  task automatic start_request(input int low_cyc);
    @(posedge ref_clk);
    low_cnt <= low_cyc;
  endtask

  // Pulldown levels only change when commanded, never in the hold window
  task automatic set_config(input logic [CFG_W-1:0] v);
    @(posedge ref_clk);
    cfg_reg <= v;
  endtask
endmodule

// ==== tb/test_hardware_reset_sequencer.sv ====
module test_hardware_reset_sequencer
  import hrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             ref_clk;
  logic             resetn;
  logic             clk_en;
  logic             end_of_init;
  logic             access_busy;
  logic             pin_level;
  logic             pin_out;
  logic             pin_oe;
  logic [CFG_W-1:0] cfg_level;
  logic             hold_cancel;
  logic             bus_drive;
  logic             ale;
  logic             internal_reset;
  logic             reset_indicator_n;
  logic             fetch_start;
  logic [15:0]      fetch_addr;
  logic             emu_sel;
  logic             sel_a;
  logic [2:0]       clk_cfg;
  int               bad_count;
  int               comparisons;
  int               cycles;

  hrs_sequencer u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reset_request_n_in(pin_level),
    .reset_request_n_out(pin_out), .reset_request_n_oe(pin_oe), .config_port(cfg_level),
    .end_of_init_instruction(end_of_init), .access_busy(access_busy), .hold_cancel(hold_cancel),
    .bus_drive(bus_drive), .ale(ale), .internal_reset(internal_reset), .reset_indicator_n(reset_indicator_n),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr), .emulation_select(emu_sel), .select_a(sel_a),
    .clock_config(clk_cfg));

  hrs_reset_source u_src (.ref_clk(ref_clk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin_level),
    .cfg_level(cfg_level));

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  // Two full sequences take about 2200 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [4:0] fld(input logic [CFG_W-1:0] v);
    return {v[CFG_EMU_BIT], v[CFG_SELA_BIT], v[CFG_W-1:CFG_CLK_LSB]};
  endfunction

  task automatic complete_run();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenario: one full reset request, optional internal access in flight
  // ---------------------------------------------------------------------------
  task automatic run_sequence(input int low_cyc, input logic [CFG_W-1:0] cfg, input int busy_cyc);
    int n;
    u_src.set_config(cfg);
    access_busy <= (busy_cyc != 0);
    u_src.start_request(low_cyc);
    for (n = 0; n < 20 && bus_drive !== 1'b0; n++) @(negedge ref_clk);
    check(n <= 5, 1'b1);
    if (busy_cyc != 0) begin
      repeat (busy_cyc) @(negedge ref_clk);
      check({pin_oe, hold_cancel}, 2'b01);
      @(posedge ref_clk);
      access_busy <= 1'b0;
      n = 0;
    end
    while (n < 40 && pin_oe !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    check((busy_cyc != 0 || n >= START_DELAY_HP) && n <= START_DELAY_MAX_HP + SYNC_STAGES + 1, 1'b1);
    check({internal_reset, reset_indicator_n}, 2'b10);
    for (n = 0; n < 1100 && pin_oe === 1'b1; n++) begin
      if (n == 100) u_src.set_config(~cfg);
      if (n == 50 || n == 110) check({emu_sel, sel_a, clk_cfg}, fld(n == 50 ? cfg : ~cfg));
      if (n == 60) check({pin_out, pin_level}, 2'b00);
      @(negedge ref_clk);
    end
    check(n, SEQ_LEN_HP);
    for (n = 0; n < 20 && internal_reset !== 1'b0; n++) @(negedge ref_clk);
    check(n >= END_DELAY_HP && n <= END_DELAY_MAX_HP + SYNC_STAGES + 1, 1'b1);
    check({bus_drive, ale}, 2'b10);
    for (n = 0; n < 20 && ale !== 1'b1; n++) @(negedge ref_clk);
    check(n, ALE_DELAY_HP);
    check({fetch_start, fetch_addr}, {1'b1, RESET_VECTOR});
    repeat (20) @(negedge ref_clk);
    check(reset_indicator_n, 1'b0);
    @(posedge ref_clk);
    end_of_init <= 1'b1;
    @(posedge ref_clk);
    end_of_init <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check(reset_indicator_n, 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // Scenario: clock enable low freezes the block, a short request is lost
  // ---------------------------------------------------------------------------
  task automatic run_freeze();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    u_src.start_request(5);
    repeat (12) @(negedge ref_clk);
    check({bus_drive, ale, internal_reset, hold_cancel}, 4'b1100);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (12) @(negedge ref_clk);
    check({bus_drive, ale, pin_oe}, 3'b110);
  endtask

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    end_of_init = 1'b0;
    access_busy = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check({internal_reset, bus_drive, pin_oe}, 3'b100);
    run_sequence(150, 16'h0001, 0);
    run_freeze();
    run_sequence(5, 16'hA002, 20);
    complete_run();
  end
endmodule
